// ===== src/acr_regs.sv
/*
  Measurement result and data-line driver register bank with its two-wire
  serial slave port. Results come from the converter with one load pulse
  per channel and are limited to their ranges before storage.
  Assumes converter results arrive on clk; the serial pins are asynchronous.
*/
`timescale 1ns/1ps
module acr_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial port pins (open drain data)
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Converter results
  input  wire logic [3:0]  result_load,
  input  wire logic [15:0] thermistor_ratio_result,
  input  wire logic [15:0] die_temperature_result,
  input  wire logic [15:0] positive_line_voltage_result,
  input  wire logic [15:0] negative_line_voltage_result,
  // Line drivers
  output logic [2:0]       positive_line_drive_level,
  output logic [2:0]       negative_line_drive_level,
  output logic             line_short
);
  import acr_pkg::*;

  typedef struct packed {
    logic        scl_q;
    logic        sda_q;
    acr_state_e  state;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  txbyte;
    logic [7:0]  shadow;
    logic [7:0]  ptr;
    logic        rw;
    logic        oe;
    logic [15:0] therm;
    logic [15:0] die;
    logic [15:0] pos;
    logic [15:0] neg;
    logic [7:0]  drv;
    logic [2:0]  pos_level;
    logic [2:0]  neg_level;
    logic        short_q;
  } acr_regs_s;

  acr_regs_s   st;
  acr_regs_s   next_st;
  logic        rst_sync_n;
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;

  // --------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------------
  acr_sync #(.W(1)) u_rst_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (1'b1),
    .q    (rst_sync_n)
  );

  acr_sync #(.W(2)) u_pin_sync (
    .clk  (clk),
    .rstn (rst_sync_n),
    .d    ({scl_in, sda_in}),
    .q    (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Limit an unsigned reading to its full scale
  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] mx);
    clamp_u = (v > mx) ? mx : v;
  endfunction : clamp_u

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] rd;
    rise  = scl_s & ~st.scl_q;
    fall  = ~scl_s & st.scl_q;
    start = scl_s & st.scl_q & st.sda_q & ~sda_s;
    stop  = scl_s & st.scl_q & ~st.sda_q & sda_s;
    rd    = UNMAPPED_READ;
    next_st = st;
    next_st.scl_q = scl_s;
    next_st.sda_q = sda_s;

    // Result capture with range limits
    if (result_load[0]) begin
      next_st.therm = clamp_u(thermistor_ratio_result, THERM_MAX);
    end
    if (result_load[1]) begin
      if ($signed(die_temperature_result) < $signed(DIE_MIN)) begin
        next_st.die = DIE_MIN;
      end else if ($signed(die_temperature_result) > $signed(DIE_MAX)) begin
        next_st.die = DIE_MAX;
      end else begin
        next_st.die = die_temperature_result;
      end
    end
    if (result_load[2]) begin
      next_st.pos = clamp_u(positive_line_voltage_result, LINE_MAX);
    end
    if (result_load[3]) begin
      next_st.neg = clamp_u(negative_line_voltage_result, LINE_MAX);
    end

    // Driver outputs follow the control fields, except that a negative field of DRV_SHORT gives DRV_HIGH_IMPEDANCE
    next_st.pos_level = st.drv[POS_LSB +: LVL_W];
    next_st.short_q   = (st.drv[POS_LSB +: LVL_W] == DRV_SHORT);
    next_st.neg_level = (st.drv[NEG_LSB +: LVL_W] == DRV_SHORT) ?
                        DRV_HIGH_IMPEDANCE : st.drv[NEG_LSB +: LVL_W];

    // Read data; a high byte read snapshots the low byte
    unique case (st.ptr)
      OFF_THERM:              rd = st.therm[15:8];
      OFF_DIE:                rd = st.die[15:8];
      OFF_POS_LINE:           rd = st.pos[15:8];
      OFF_NEG_LINE:           rd = st.neg[15:8];
      OFF_THERM + ADDR_STEP,
      OFF_DIE + ADDR_STEP,
      OFF_POS_LINE + ADDR_STEP,
      OFF_NEG_LINE + ADDR_STEP: rd = st.shadow;
      OFF_DRV_CTRL:           rd = st.drv;
      default:                rd = UNMAPPED_READ;
    endcase

    // Serial slave
    if (start) begin
      next_st.state  = ST_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.oe     = 1'b0;
    end else if (stop) begin
      next_st.state = ST_IDLE;
      next_st.oe    = 1'b0;
    end else if (rise) begin
      unique case (st.state)
        ST_ADDR, ST_WREG, ST_WDATA: begin
          next_st.shreg  = {st.shreg[6:0], sda_s};
          next_st.bitcnt = st.bitcnt + 4'h1;
        end
        ST_RDATA: next_st.bitcnt = st.bitcnt + 4'h1;
        ST_RACK:  if (sda_s) next_st.state = ST_IDLE; // Host ended the read
        default: ;
      endcase
    end else if (fall) begin
      unique case (st.state)
        ST_ADDR: if (st.bitcnt == BITS_PER_BYTE) begin
          if (st.shreg[7:1] == DEV_ADDR) begin
            next_st.oe    = 1'b1;
            next_st.rw    = st.shreg[0];
            next_st.state = ST_ADDR_ACK;
          end else begin
            next_st.state = ST_IDLE;
          end
        end
        ST_ADDR_ACK, ST_RACK: begin
          next_st.bitcnt = 4'h0;
          if (st.rw) begin
            next_st.txbyte = rd;
            next_st.oe     = ~rd[7];
            next_st.ptr    = st.ptr + ADDR_STEP;
            next_st.state  = ST_RDATA;
            unique case (st.ptr)
              OFF_THERM:    next_st.shadow = st.therm[7:0];
              OFF_DIE:      next_st.shadow = st.die[7:0];
              OFF_POS_LINE: next_st.shadow = st.pos[7:0];
              OFF_NEG_LINE: next_st.shadow = st.neg[7:0];
              default: ;
            endcase
          end else begin
            next_st.oe    = 1'b0;
            next_st.state = ST_WREG;
          end
        end
        ST_WREG, ST_WDATA: if (st.bitcnt == BITS_PER_BYTE) begin
          next_st.oe    = 1'b1;
          next_st.state = ST_WACK;
          if (st.state == ST_WREG) begin
            next_st.ptr = st.shreg;
          end else begin
            next_st.ptr = st.ptr + ADDR_STEP;
            if (st.ptr == OFF_DRV_CTRL) begin
              next_st.drv = st.shreg;
            end
          end
        end
        ST_WACK: begin
          next_st.oe     = 1'b0;
          next_st.bitcnt = 4'h0;
          next_st.state  = ST_WDATA;
        end
        ST_RDATA: if (st.bitcnt == BITS_PER_BYTE) begin
          next_st.oe    = 1'b0;
          next_st.state = ST_RACK;
        end else begin
          next_st.txbyte = {st.txbyte[6:0], 1'b0};
          next_st.oe     = ~st.txbyte[6];
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out                   = 1'b0;
  assign sda_oe                    = st.oe;
  assign positive_line_drive_level = st.pos_level;
  assign negative_line_drive_level = st.neg_level;
  assign line_short                = st.short_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_drv_change;
    st.drv != $past(st.drv);
  endsequence

  sequence s_pos_follow;
    ##1 positive_line_drive_level == $past(st.drv[POS_LSB +: LVL_W]);
  endsequence

  property p_therm_load;
    result_load[0] && thermistor_ratio_result <= THERM_MAX
      |=> st.therm == $past(thermistor_ratio_result);
  endproperty
  a_therm_load: assert property (p_therm_load) else $error("thermistor load lost");

  property p_therm_cap;
    result_load[0] && thermistor_ratio_result > THERM_MAX |=> st.therm == THERM_MAX;
  endproperty
  a_therm_cap: assert property (p_therm_cap) else $error("thermistor not capped");

  property p_die_neg;
    result_load[1] && $signed(die_temperature_result) < 0
      && $signed(die_temperature_result) >= $signed(DIE_MIN) |=> $signed(st.die) < 0;
  endproperty
  a_die_neg: assert property (p_die_neg) else $error("negative die temp lost sign");

  property p_die_step;
    result_load[1] && $signed(die_temperature_result) <= $signed(DIE_MAX)
      && $signed(die_temperature_result) >= $signed(DIE_MIN)
      |=> st.die == $past(die_temperature_result);
  endproperty
  a_die_step: assert property (p_die_step) else $error("die temp altered");

  property p_die_range;
    $signed(st.die) >= $signed(DIE_MIN) && $signed(st.die) <= $signed(DIE_MAX);
  endproperty
  a_die_range: assert property (p_die_range) else $error("die temp out of range");

  property p_pos_line;
    result_load[2] |=> st.pos <= LINE_MAX && (st.pos == LINE_MAX
      || st.pos == $past(positive_line_voltage_result));
  endproperty
  a_pos_line: assert property (p_pos_line) else $error("positive line reading wrong");

  property p_neg_line;
    result_load[3] |=> st.neg <= LINE_MAX && (st.neg == LINE_MAX
      || st.neg == $past(negative_line_voltage_result));
  endproperty
  a_neg_line: assert property (p_neg_line) else $error("negative line reading wrong");

  property p_pos_drive;
    s_drv_change |-> s_pos_follow ##0 (line_short == (positive_line_drive_level == DRV_SHORT));
  endproperty
  a_pos_drive: assert property (p_pos_drive) else $error("positive driver mismatch");

  property p_neg_reserved;
    st.drv[NEG_LSB +: LVL_W] == DRV_SHORT [*2] |-> negative_line_drive_level == DRV_HIGH_IMPEDANCE;
  endproperty
  a_neg_reserved: assert property (p_neg_reserved) else $error("reserved code driven");

endmodule : acr_regs

// ===== src/acr_pkg.sv
/*
  Constants, register map, field layout and state encoding of the measurement
  result and data-line driver register bank.
  Assumes one 125 MHz clock domain and a host reaching the bank over a
  two-wire serial port whose pins pass through synchronisers in the top.
*/
package acr_pkg;

  // --------------------------------------------------------------------------
  // Register offsets (high byte at the printed offset, low byte at +1)
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFF_THERM      = 8'h3F;
  localparam logic [7:0] OFF_DIE        = 8'h41;
  localparam logic [7:0] OFF_POS_LINE   = 8'h43;
  localparam logic [7:0] OFF_NEG_LINE   = 8'h45;
  localparam logic [7:0] OFF_DRV_CTRL   = 8'h47;
  localparam logic [7:0] ADDR_STEP      = 8'h01;

  // --------------------------------------------------------------------------
  // Reset values and result limits
  // --------------------------------------------------------------------------
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [7:0]  DRV_RESET     = 8'h00;
  localparam logic [15:0] THERM_MAX     = 16'h03FF;  // 1023 steps of 1/1024
  localparam logic [15:0] DIE_MIN       = 16'hFFB0;  // -80 half degrees
  localparam logic [15:0] DIE_MAX       = 16'h012C;  // 300 half degrees
  localparam logic [15:0] LINE_MAX      = 16'h0E10;  // 3600 mV

  // --------------------------------------------------------------------------
  // Driver control field layout and codes
  // --------------------------------------------------------------------------
  localparam int          POS_LSB       = 5;
  localparam int          NEG_LSB       = 2;
  localparam int          LVL_W         = 3;
  localparam logic [2:0]  DRV_HIGH_IMPEDANCE = 3'h0;
  localparam logic [2:0]  DRV_SHORT     = 3'h7;

  // --------------------------------------------------------------------------
  // Serial port
  // --------------------------------------------------------------------------
  localparam logic [6:0]  DEV_ADDR      = 7'h2A;     // Arbitrary value
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WREG, ST_WACK, ST_WDATA, ST_RDATA, ST_RACK
  } acr_state_e;

endpackage : acr_pkg

// ===== src/acr_sync.sv
/*
  Two flip-flop level synchroniser, one lane per bit.
  Assumes the inputs are levels from outside the clock domain; the first
  stage is read by the second stage only.
*/
`timescale 1ns/1ps
module acr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // --------------------------------------------------------------------------
  // Per-bit two stage chain
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic stage1;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stage1 <= 1'b0;
          q[i]   <= 1'b0;
        end else begin
          stage1 <= d[i];
          q[i]   <= stage1;
        end
      end
    end
  endgenerate

endmodule : acr_sync

// ===== verification/acr_host.sv
/*
  Host controller model: bit-level master of the two-wire serial port.
  Assumes a pulled-up data wire resolved by the bench; 8 clk cycles a phase.
*/
`timescale 1ns/1ps
module acr_host (
  // Clock
  input  wire logic clk,
  // Bus wires
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  import acr_pkg::*;

  logic [6:0] dev_addr = DEV_ADDR;

  // ---------------------------------------------------------------------------
  // Bus phases
  // ---------------------------------------------------------------------------
  // Idle bus: clock high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // One phase, changes land on falling clk
  task automatic hold();
    repeat (8) @(negedge clk);
  endtask : hold
  // One bit; data never moves while clock is high
  task automatic bitx(input logic drv_low, output logic seen);
    sda_low = drv_low;
    hold();
    scl = 1'b1;
    hold();
    seen = sda_line;
    scl = 1'b0;
    hold();
  endtask : bitx
  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask : stop
  // Byte plus ninth bit; tx of all ones releases the wire for reads
  task automatic xfer(input logic [7:0] tx, input logic host_ack, input logic want_ack,
                      output logic [7:0] rx, inout logic ok);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(~tx[i], b);
      rx[i] = b;
    end
    bitx(host_ack, b);
    ok = ok & (~want_ack | ~b);
  endtask : xfer
  // Register write: address, pointer, one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    ok = 1'b1;
    start();
    xfer({dev_addr, 1'b0}, 1'b0, 1'b1, rx, ok);
    xfer(a, 1'b0, 1'b1, rx, ok);
    xfer(d, 1'b0, 1'b1, rx, ok);
    stop();
  endtask : wr
  // Register read of n bytes, high byte first, last byte refused
  task automatic rd(input logic [7:0] a, input int n, output logic [15:0] v,
                    output logic ok);
    logic [7:0] rx;
    ok = 1'b1;
    v  = 16'h0000;
    start();
    xfer({dev_addr, 1'b0}, 1'b0, 1'b1, rx, ok);
    xfer(a, 1'b0, 1'b1, rx, ok);
    start();
    xfer({dev_addr, 1'b1}, 1'b0, 1'b1, rx, ok);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i < n - 1, 1'b0, rx, ok);
      v = {v[7:0], rx};
    end
    stop();
  endtask : rd
endmodule : acr_host

// ===== verification/acr_regs_bench.sv
/*
  Self-checking bench of the result and line driver register bank.
  Assumes the host model drives the serial wires; bench feeds the converter.
*/
`timescale 1ns/1ps
module acr_regs_bench;
  import acr_pkg::*;

  logic        clk         = 1'b0;
  logic        rstn        = 1'b0;
  logic [3:0]  result_load = 4'h0;
  logic [15:0] res [4]     = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic        sda_out;
  logic        sda_oe;
  logic        scl;
  logic        sda_low;
  logic [2:0]  pos_lvl;
  logic [2:0]  neg_lvl;
  logic        line_short;
  int          err_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  logic [7:0]  offs [4]   = '{OFF_THERM, OFF_DIE, OFF_POS_LINE, OFF_NEG_LINE};
  // Pulled-up wire, low when either party pulls
  wire         sda_line   = ~sda_low & ~(sda_oe & ~sda_out);

  always #4 clk = ~clk;

  acr_regs DUT (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .result_load(result_load),
    .thermistor_ratio_result(res[0]), .die_temperature_result(res[1]),
    .positive_line_voltage_result(res[2]), .negative_line_voltage_result(res[3]),
    .positive_line_drive_level(pos_lvl), .negative_line_drive_level(neg_lvl),
    .line_short(line_short));
  acr_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Hang guard, about two and a half times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      err_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Every register and driver output clear after reset
  task automatic test_reset();
    logic [15:0] v;
    logic        ok;
    for (int i = 0; i < 4; i++) begin
      host.rd(offs[i], 2, v, ok);
      check("result reset", v, RESULT_RESET);
    end
    host.rd(OFF_DRV_CTRL, 1, v, ok);
    check("driver reset", v, 16'(DRV_RESET));
    check("driver pins", 16'({pos_lvl, neg_lvl, line_short}), 16'h0000);
    $display("test_reset done");
  endtask : test_reset
  // Loads at and beyond range limits, host write attempts ignored
  task automatic test_results();
    logic [1:0]  ch [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
                             2'h2, 2'h2, 2'h3, 2'h3};
    logic [15:0] vi [11] = '{16'h0123, 16'h03FF, 16'hFFFF, 16'hFFB0, 16'h0051, 16'h8000,
                             16'h012D, 16'h0E10, 16'h0E11, 16'h0001, 16'hFFFF};
    logic [15:0] ve [11] = '{16'h0123, 16'h03FF, 16'h03FF, 16'hFFB0, 16'h0051, 16'hFFB0,
                             16'h012C, 16'h0E10, 16'h0E10, 16'h0001, 16'h0E10};
    logic [15:0] v;
    logic        ok;
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      res[ch[i]]  = vi[i];
      result_load = 4'h1 << ch[i];
      @(negedge clk);
      result_load = 4'h0;
      host.wr(offs[ch[i]], 8'h5A, ok);
      host.rd(offs[ch[i]], 2, v, ok);
      check("result read", v, ve[i]);
      check("result ack", 16'(ok), 16'h0001);
    end
    $display("test_results done");
  endtask : test_results
  // Every code of both driver fields, outputs and read back
  task automatic test_driver();
    logic [15:0] v;
    logic        ok;
    logic [2:0]  p;
    logic [2:0]  n;
    for (int i = 0; i < 8; i++) begin
      p = 3'(i);
      n = 3'(7 - i);
      host.wr(OFF_DRV_CTRL, {p, n, 2'b00}, ok);
      repeat (2) @(negedge clk);
      check("positive level", 16'(pos_lvl), 16'(p));
      check("negative level", 16'(neg_lvl), (n == 3'h7) ? 16'(DRV_HIGH_IMPEDANCE) : 16'(n));
      check("line short", 16'(line_short), 16'(p == DRV_SHORT));
      host.rd(OFF_DRV_CTRL, 1, v, ok);
      check("driver read", v, 16'({p, n, 2'b00}));
    end
    $display("test_driver done");
  endtask : test_driver
  // Foreign device address and unmapped offset
  task automatic test_refusal();
    logic [15:0] v;
    logic        ok;
    host.dev_addr = DEV_ADDR ^ 7'h01;
    host.rd(OFF_DRV_CTRL, 1, v, ok);
    check("foreign address ack", 16'(ok), 16'h0000);
    host.dev_addr = DEV_ADDR;
    host.rd(8'h50, 1, v, ok);
    check("unmapped read", v, 16'(UNMAPPED_READ));
    check("driver kept", 16'(pos_lvl), 16'h0007);
    $display("test_refusal done");
  endtask : test_refusal

  // Main sequence: reset, settle, scenarios, verdict
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    test_reset();
    test_results();
    test_driver();
    test_refusal();
    end_of_test();
  end
endmodule : acr_regs_bench
